// [verilog/eisbr_pkg.sv]
package eisbr_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] OFF_INSTR   = 8'h00;
	localparam logic [7:0] OFF_SRCOP   = 8'h04;
	localparam logic [7:0] OFF_DSTOP   = 8'h08;
	localparam logic [7:0] OFF_RESULT  = 8'h0c;
	localparam logic [7:0] OFF_PSW     = 8'h10;
	localparam logic [7:0] OFF_PC      = 8'h14;
	localparam logic [7:0] OFF_DECODE  = 8'h18;
	localparam logic [7:0] OFF_IRQSTAT = 8'h1c;
	localparam logic [7:0] OFF_IRQMASK = 8'h20;
	localparam int         GPR_SEL_BIT = 6;       // Address bit that selects the general registers
	localparam logic [1:0] GPR_TOP     = 2'h1;    // Address bits 7:6 of the general register window

	// Word and field sizes
	localparam int WORD      = 16;
	localparam int NREGS     = 8;
	localparam int SPEC_BITS = 3;

	// Opcode patterns
	localparam logic [15:0] EIS_MASK                = 16'hfe00;
	localparam logic [15:0] SIGNED_MULTIPLY_OP      = 16'h7000;
	localparam logic [15:0] SIGNED_DIVIDE_OP        = 16'h7200;
	localparam logic [15:0] REG_XOR_OP              = 16'h7800;
	localparam logic [15:0] BRANCH_MASK             = 16'hff00;
	localparam logic [15:0] BRANCH_ALWAYS_OP        = 16'h0100;
	localparam logic [15:0] BRANCH_NOT_ZERO_OP      = 16'h0200;
	localparam logic [15:0] BRANCH_ZERO_OP          = 16'h0300;
	localparam logic [15:0] BRANCH_SIGNED_GE_OP     = 16'h0400;

	// Instruction fields
	localparam int REG_LSB    = 6;
	localparam int MODE_LSB   = 3;
	localparam int SPREG_LSB  = 0;
	localparam int OFFSET_MSB = 7;
	localparam logic [2:0] MODE_REGISTER = 3'h0;

	// Condition flag positions in the status word
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_V = 1;
	localparam int FLAG_C = 0;

	// Single-word signed limits
	localparam logic signed [31:0] WORD_MAX = 32'sh00007fff;
	localparam logic signed [31:0] WORD_MIN = -32'sh00008000;

	// Interrupt status bits and the decode busy bit
	localparam int IRQ_BITS   = 4;
	localparam int EV_DONE    = 0;
	localparam int EV_DIVOVF  = 1;
	localparam int EV_DIVZERO = 2;
	localparam int EV_BADOP   = 3;
	localparam int BUSY_BIT   = 15;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DIVWAIT} eisbr_state_t;

endpackage

// [verilog/eisbr_udiv.sv]
`timescale 1ns/1ps
`default_nettype none

// Restoring unsigned divider, one quotient bit per clock; caller keeps dividend high half below divisor
module eisbr_udiv
#(
	parameter int W = 16
)
(
	input  wire logic           clk,       // Clock
	input  wire logic           reset,     // Synchronous reset
	input  wire logic           start,     // Start pulse
	input  wire logic [2*W-1:0] dividend,  // Unsigned dividend
	input  wire logic [W-1:0]   divisor,   // Unsigned divisor
	output logic      [W-1:0]   quotient,  // Quotient
	output logic      [W-1:0]   remainder, // Remainder
	output logic                done       // One-cycle completion pulse
);

	logic [2*W-1:0]         acc_q;
	logic [W-1:0]           dvs_q;
	logic [$clog2(W+1)-1:0] cnt_q;
	logic                   run_q;
	logic                   done_q;
	logic [W:0]             trial;
	logic [2*W-1:0]         acc_d;

	// Trial subtraction of the divisor from the shifted partial remainder
	assign trial = acc_q[2*W-1:W-1] - {1'b0, dvs_q};
	assign acc_d = trial[W] ? {acc_q[2*W-2:0], 1'b0} : {trial[W-1:0], acc_q[W-2:0], 1'b1};

	assign quotient  = acc_q[W-1:0];
	assign remainder = acc_q[2*W-1:W];
	assign done      = done_q;

	// Iteration state
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			acc_q  <= '0;
			dvs_q  <= '0;
			cnt_q  <= '0;
			run_q  <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= run_q && (cnt_q == ($clog2(W+1))'(W - 1));
			if (start)
			begin
				acc_q <= dividend;
				dvs_q <= divisor;
				cnt_q <= '0;
				run_q <= 1'b1;
			end
			else if (run_q)
			begin
				acc_q <= acc_d;
				cnt_q <= cnt_q + 1'b1;
				run_q <= (cnt_q != ($clog2(W+1))'(W - 1));
			end
		end
	end

endmodule

`default_nettype wire

// [verilog/eisbr_core.sv]
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE1 - Multiply signed; even register gets high, next low
// RULE2 - Odd multiply register keeps only low product
// RULE3 - Multiply flags: N, Z, V clear, C out-of-range
// RULE4 - Divide even pair by source; quotient to even
// RULE5 - Remainder to odd register, sign of dividend
// RULE6 - Zero divisor or quotient overflow sets V, aborts
// RULE7 - Divide sets C only on zero divisor
// RULE8 - Divide N and Z follow the quotient
// RULE9 - Exclusive-OR register into destination, register kept
// RULE10 - Exclusive-OR flags: N, Z, V clear, C kept
// RULE11 - Unconditional branch adds twice signed offset
// RULE12 - Not-zero branch taken when Z clear
// RULE13 - Zero branch taken when Z set
// RULE14 - Signed greater-or-equal branch when N equals V
// RULE15 - Six-bit specifier splits into mode and register
// RULE16 - Offset: low eight bits, sign-extended, doubled
// RULE17 - Branches leave all four flags unchanged
module eisbr_core
	import eisbr_pkg::*;
(
	input  wire logic        clk,       // Clock, 250 MHz
	input  wire logic        reset,     // Synchronous reset, active high
	input  wire logic        hsel,      // Slave select
	input  wire logic [31:0] haddr,     // Byte address
	input  wire logic [1:0]  htrans,    // Transfer type
	input  wire logic        hwrite,    // Write when high
	input  wire logic [2:0]  hsize,     // Transfer size, word only
	input  wire logic [31:0] hwdata,    // Write data
	input  wire logic        hready,    // Bus ready
	output logic      [31:0] hrdata,    // Read data
	output logic             hreadyout, // Slave ready
	output logic             hresp,     // Response, always OKAY
	output logic             irq        // Level interrupt
);

	////////////////////////////////////////////////////////////////////////////
	// State
	logic [WORD-1:0]     gpr_q [NREGS];
	logic [WORD-1:0]     gpr_d [NREGS];
	logic [WORD-1:0]     instr_q, srcOp_q, dstOp_q, result_q, pc_q;
	logic [WORD-1:0]     result_d, pc_d;
	logic [3:0]          psw_q, psw_d;
	logic [IRQ_BITS-1:0] irqStat_q, irqStat_d, irqMask_q, events;
	eisbr_state_t        state_q, state_d;
	logic [7:0]          addr_q;
	logic                wr_q, rd_q, hit_q;
	logic [31:0]         hrdata_q;
	logic                hreadyout_q, irq_q;
	logic                divNeg_q, remNeg_q;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic        takeAddr;
	logic        wInstr, wSrc, wDst, wPsw, wPc, wStat, wMask, wGpr;
	logic [31:0] rdMux;
	logic [2:0]  gprSel;

	assign takeAddr = hsel && hready && htrans[1];
	assign gprSel   = addr_q[4:2];
	assign wGpr     = wr_q && hit_q && (addr_q[7:6] == GPR_TOP);
	assign wInstr   = wr_q && hit_q && (addr_q == OFF_INSTR) && (state_q == ST_IDLE);
	assign wSrc     = wr_q && hit_q && (addr_q == OFF_SRCOP);
	assign wDst     = wr_q && hit_q && (addr_q == OFF_DSTOP);
	assign wPsw     = wr_q && hit_q && (addr_q == OFF_PSW);
	assign wPc      = wr_q && hit_q && (addr_q == OFF_PC);
	assign wStat    = wr_q && hit_q && (addr_q == OFF_IRQSTAT);
	assign wMask    = wr_q && hit_q && (addr_q == OFF_IRQMASK);

	// Read multiplexer; unmapped addresses read zero
	assign rdMux = !hit_q                      ? 32'h00000000 :
		(addr_q[7:6] == GPR_TOP)                 ? {16'h0000, gpr_q[gprSel]} :
		(addr_q == OFF_INSTR)                    ? {16'h0000, instr_q} :
		(addr_q == OFF_SRCOP)                    ? {16'h0000, srcOp_q} :
		(addr_q == OFF_DSTOP)                    ? {16'h0000, dstOp_q} :
		(addr_q == OFF_RESULT)                   ? {16'h0000, result_q} :
		(addr_q == OFF_PSW)                      ? {28'h0000000, psw_q} :
		(addr_q == OFF_PC)                       ? {16'h0000, pc_q} :
		(addr_q == OFF_DECODE)                   ? {16'h0000, state_q != ST_IDLE, 6'h00, instr_q[8:0]} :
		(addr_q == OFF_IRQSTAT)                  ? {28'h0000000, irqStat_q} :
		(addr_q == OFF_IRQMASK)                  ? {28'h0000000, irqMask_q} : 32'h00000000;

	////////////////////////////////////////////////////////////////////////////
	// Instruction decode
	logic [2:0]      rIdx, rOdd, sMode, sReg;
	logic [WORD-1:0] rVal, srcVal, dstVal, xorRes;
	logic            isMultiply, isDiv, isXor, isBranchAlways, isBranchNotZero, isBranchZero;
	logic            isBranchSignedGe, isBranch, taken;
	logic [WORD-1:0] branchDisp;

	assign rIdx   = instr_q[REG_LSB +: SPEC_BITS];
	assign rOdd   = rIdx | 3'h1;
	assign sMode  = instr_q[MODE_LSB +: SPEC_BITS];                                           // RULE15
	assign sReg   = instr_q[SPREG_LSB +: SPEC_BITS];                                          // RULE15
	assign rVal   = gpr_q[rIdx];
	assign srcVal = (sMode == MODE_REGISTER) ? gpr_q[sReg] : srcOp_q;                        // RULE15
	assign dstVal = (sMode == MODE_REGISTER) ? gpr_q[sReg] : dstOp_q;                        // RULE15
	assign isMultiply       = (instr_q & EIS_MASK) == SIGNED_MULTIPLY_OP;
	assign isDiv            = (instr_q & EIS_MASK) == SIGNED_DIVIDE_OP;
	assign isXor            = (instr_q & EIS_MASK) == REG_XOR_OP;
	assign isBranchAlways   = (instr_q & BRANCH_MASK) == BRANCH_ALWAYS_OP;
	assign isBranchNotZero  = (instr_q & BRANCH_MASK) == BRANCH_NOT_ZERO_OP;
	assign isBranchZero     = (instr_q & BRANCH_MASK) == BRANCH_ZERO_OP;
	assign isBranchSignedGe = (instr_q & BRANCH_MASK) == BRANCH_SIGNED_GE_OP;
	assign isBranch = isBranchAlways || isBranchNotZero || isBranchZero || isBranchSignedGe;

	// Branch condition and displacement
	assign taken = isBranchAlways                                                             // RULE11
		|| (isBranchNotZero && !psw_q[FLAG_Z])                                                // RULE12
		|| (isBranchZero && psw_q[FLAG_Z])                                                    // RULE13
		|| (isBranchSignedGe && !(psw_q[FLAG_N] ^ psw_q[FLAG_V]));                            // RULE14
	assign branchDisp = {{(WORD - OFFSET_MSB - 2){instr_q[OFFSET_MSB]}}, instr_q[OFFSET_MSB:0], 1'b0}; // RULE16

	////////////////////////////////////////////////////////////////////////////
	// Multiply and exclusive-OR datapath
	logic signed [31:0] prod;
	logic               prodOut;

	assign prod    = $signed(rVal) * $signed(srcVal);                                          // RULE1
	assign prodOut = (prod > WORD_MAX) || (prod < WORD_MIN);                                   // RULE3
	assign xorRes  = rVal ^ dstVal;                                                            // RULE9

	////////////////////////////////////////////////////////////////////////////
	// Divide: signs and magnitudes, overflow screen, unsigned core
	logic [31:0]     dvd, absDvd;
	logic [WORD-1:0] absDvs, uQuo, uRem, quo, remv;
	logic            divZero, divOvf, badDiv, divStart, divDone;

	assign dvd     = {rVal, gpr_q[rOdd]};                                                      // RULE4
	assign absDvd  = dvd[31] ? 32'(-dvd) : dvd;
	assign absDvs  = srcVal[WORD-1] ? WORD'(-srcVal) : srcVal;
	assign divZero = (srcVal == '0);                                                           // RULE6
	assign divOvf  = divZero || (absDvd[31:WORD-1] >= {1'b0, absDvs});                         // RULE6
	assign badDiv  = isDiv && rIdx[0];                                                         // RULE4
	assign divStart = (state_q == ST_EXEC) && isDiv && !badDiv && !divOvf;
	assign quo     = divNeg_q ? WORD'(-uQuo) : uQuo;
	assign remv    = remNeg_q ? WORD'(-uRem) : uRem;                                           // RULE5

	eisbr_udiv #(.W(WORD)) u_udiv
	(
		.clk       (clk),
		.reset     (reset),
		.start     (divStart),
		.dividend  (absDvd),
		.divisor   (absDvs),
		.quotient  (uQuo),
		.remainder (uRem),
		.done      (divDone)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state of registers, flags and program counter
	always_comb
	begin
		for (int i = 0; i < NREGS; i++)
			gpr_d[i] = gpr_q[i];
		if (wGpr)
			gpr_d[gprSel] = hwdata[WORD-1:0];
		psw_d    = wPsw ? hwdata[3:0] : psw_q;
		pc_d     = wPc ? hwdata[WORD-1:0] : pc_q;
		result_d = result_q;
		events   = '0;
		state_d  = state_q;
		unique case (state_q)
			ST_IDLE:
				if (wInstr)
					state_d = ST_EXEC;
			ST_EXEC:
			begin
				state_d = ST_IDLE;
				events[EV_DONE] = 1'b1;
				if (isMultiply)
				begin
					if (rIdx[0])
						gpr_d[rIdx] = prod[WORD-1:0];                                         // RULE2
					else
					begin
						gpr_d[rIdx] = prod[31:WORD];                                          // RULE1
						gpr_d[rOdd] = prod[WORD-1:0];                                         // RULE1
					end
					psw_d = {prod < 0, prod == 0, 1'b0, prodOut};                             // RULE3
				end
				else if (isDiv && !badDiv)
				begin
					if (divOvf)
					begin
						psw_d[FLAG_V] = 1'b1;                                                 // RULE6
						psw_d[FLAG_C] = divZero;                                              // RULE7
						events[EV_DIVOVF]  = 1'b1;
						events[EV_DIVZERO] = divZero;
					end
					else
					begin
						state_d = ST_DIVWAIT;
						events[EV_DONE] = 1'b0;
					end
				end
				else if (isXor)
				begin
					result_d = xorRes;                                                        // RULE9
					if (instr_q[REG_LSB-1 -: SPEC_BITS] == MODE_REGISTER)
						gpr_d[sReg] = xorRes;                                                 // RULE9
					psw_d = {xorRes[WORD-1], xorRes == '0, 1'b0, psw_q[FLAG_C]};              // RULE10
				end
				else if (isBranch)
				begin
					if (taken)
						pc_d = pc_q + branchDisp;                                             // RULE16
					psw_d = psw_q;                                                            // RULE17
				end
				else
					events[EV_BADOP] = 1'b1;
			end
			ST_DIVWAIT:
				if (divDone)
				begin
					state_d = ST_IDLE;
					events[EV_DONE] = 1'b1;
					gpr_d[rIdx] = quo;                                                        // RULE4
					gpr_d[rOdd] = remv;                                                       // RULE5
					psw_d = {quo[WORD-1], quo == '0, 1'b0, 1'b0};                             // RULE8
				end
			default:
				state_d = ST_IDLE;
		endcase
	end

	assign irqStat_d = (irqStat_q & ~(wStat ? hwdata[IRQ_BITS-1:0] : '0)) | events;

	////////////////////////////////////////////////////////////////////////////
	// Bus slave phase tracking and answer
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			addr_q      <= '0;
			wr_q        <= 1'b0;
			rd_q        <= 1'b0;
			hit_q       <= 1'b0;
			hrdata_q    <= '0;
			hreadyout_q <= 1'b1;
		end
		else
		begin
			addr_q      <= takeAddr ? haddr[7:0] : addr_q;
			hit_q       <= takeAddr ? (haddr[31:8] == '0) : hit_q;
			wr_q        <= takeAddr && hwrite;
			rd_q        <= takeAddr && !hwrite;
			hreadyout_q <= !(takeAddr && !hwrite);
			hrdata_q    <= rd_q ? rdMux : hrdata_q;
		end
	end

	// Architectural state
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < NREGS; i++)
				gpr_q[i] <= '0;
			instr_q   <= '0;
			srcOp_q   <= '0;
			dstOp_q   <= '0;
			result_q  <= '0;
			pc_q      <= '0;
			psw_q     <= '0;
			state_q   <= ST_IDLE;
		end
		else
		begin
			for (int i = 0; i < NREGS; i++)
				gpr_q[i] <= gpr_d[i];
			instr_q   <= wInstr ? hwdata[WORD-1:0] : instr_q;
			srcOp_q   <= wSrc ? hwdata[WORD-1:0] : srcOp_q;
			dstOp_q   <= wDst ? hwdata[WORD-1:0] : dstOp_q;
			result_q  <= result_d;
			pc_q      <= pc_d;
			psw_q     <= psw_d;
			state_q   <= state_d;
		end
	end

	// Divide sign capture and interrupt logic
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			divNeg_q  <= 1'b0;
			remNeg_q  <= 1'b0;
			irqStat_q <= '0;
			irqMask_q <= '0;
			irq_q     <= 1'b0;
		end
		else
		begin
			divNeg_q  <= divStart ? (dvd[31] ^ srcVal[WORD-1]) : divNeg_q;
			remNeg_q  <= divStart ? dvd[31] : remNeg_q;                                       // RULE5
			irqStat_q <= irqStat_d;
			irqMask_q <= wMask ? hwdata[IRQ_BITS-1:0] : irqMask_q;
			irq_q     <= |(irqStat_d & (wMask ? hwdata[IRQ_BITS-1:0] : irqMask_q));
		end
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp     = 1'b0;
	assign irq       = irq_q;

endmodule

`default_nettype wire

// [test/eisbr_checker.sv]
`timescale 1ns/1ps
`default_nettype none

// Bus and interrupt watcher on the core ports
module eisbr_checker
(
	input wire logic        clk,       // Clock
	input wire logic        reset,     // Reset
	input wire logic        hsel,      // Select
	input wire logic [31:0] haddr,     // Address
	input wire logic [1:0]  htrans,    // Transfer type
	input wire logic        hwrite,    // Write
	input wire logic        hready,    // Bus ready
	input wire logic [31:0] hrdata,    // Read data
	input wire logic        hreadyout, // Slave ready
	input wire logic        hresp,     // Response
	input wire logic        irq        // Interrupt
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Taken transfers and unmapped places
	wire logic rdTaken = hsel && hready && htrans[1] && !hwrite;
	wire logic wrTaken = hsel && hready && htrans[1] && hwrite;
	wire logic lowPage = haddr[31:8] == 24'h0;
	wire logic unmapped = !lowPage || (haddr[7:0] >= 8'h24 && haddr[7:0] < 8'h40);

	AST_OKAY: assert property (hresp == 1'b0)
		else $error("response not OKAY");
	AST_READ_WAIT: assert property (rdTaken |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	AST_WRITE_NOWAIT: assert property (wrTaken |=> hreadyout)
		else $error("write was stalled");
	AST_WAIT_CAUSE: assert property ($fell(hreadyout) |-> $past(rdTaken))
		else $error("wait state without read");
	AST_HRDATA_HOLD: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved while idle");
	AST_UNMAPPED_ZERO: assert property (rdTaken && unmapped |-> ##2 hrdata == 32'h0)
		else $error("unmapped read not zero");
	AST_UPPER_ZERO: assert property (rdTaken && lowPage && haddr[7:0] < 8'h80 |-> ##2 hrdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
	AST_RESET_QUIET: assert property ($fell(reset) |-> !irq && hreadyout)
		else $error("outputs not idle after reset");
endmodule

bind eisbr_core eisbr_checker i_chk (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

`default_nettype wire

// [test/tb_eis_and_branch_execute.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_eis_and_branch_execute;
	import eisbr_pkg::*;

	logic             clk, reset, hsel, hwrite;
	logic [31:0]      haddr, hwdata;
	logic [1:0]       htrans;
	logic [2:0]       hsize;
	wire logic [31:0] hrdata;
	wire logic        hreadyout, hresp, irq;
	int               error_cnt, n_compared;
	logic [15:0]      mr [NREGS];
	logic [3:0]       mpsw;
	logic [15:0]      mpc;
	localparam logic [15:0] OPS [7] = '{SIGNED_MULTIPLY_OP, SIGNED_DIVIDE_OP, REG_XOR_OP, BRANCH_ALWAYS_OP,
		BRANCH_NOT_ZERO_OP, BRANCH_ZERO_OP, BRANCH_SIGNED_GE_OP};

	////////////////////////////////////////
	// Core with its ready looped back
	eisbr_core i_dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .irq(irq));

	// Clock and watchdog
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		#160000;
		error_cnt++;
		stop_test();
	end

	////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One single transfer: address phase, then data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask

	// Execute one instruction, update the model, compare everything
	task automatic run(input logic [15:0] ins, input logic [15:0] sop);
		logic [31:0] d;
		logic signed [31:0] p, m;
		logic [2:0] r;
		logic [15:0] s, o;
		logic t;
		logic [3:0] ev;
		r = ins[8:6];
		s = (ins[5:3] == MODE_REGISTER) ? mr[ins[2:0]] : sop;
		ev = 4'h0;
		ev[EV_DONE] = 1'b1;
		wr(OFF_SRCOP, {16'h0, sop});
		wr(OFF_DSTOP, {16'h0, sop});
		wr(OFF_IRQSTAT, 32'hf);
		wr(OFF_INSTR, {16'h0, ins});
		do xfer(1'b0, OFF_DECODE, 32'h0, d); while (d[BUSY_BIT] !== 1'b0);
		check("decode", d, {23'h0, ins[8:0]});
		case (ins & EIS_MASK)
			SIGNED_MULTIPLY_OP:
			begin
				p = $signed(mr[r]) * $signed(s);
				if (r[0])
					mr[r] = p[15:0];
				else
					{mr[r], mr[r + 3'h1]} = p;
				mpsw = {p < 0, p == 0, 1'b0, p > WORD_MAX || p < WORD_MIN};
			end
			SIGNED_DIVIDE_OP:
				if (r[0])
					ev[EV_BADOP] = 1'b1;
				else
				begin
					m = {mr[r], mr[r + 3'h1]};
					if (s == 16'h0)
					begin
						mpsw[1:0] = 2'b11;
						ev[EV_DIVOVF] = 1'b1;
						ev[EV_DIVZERO] = 1'b1;
					end
					else
					begin
						p = m / $signed(s);
						if (p > WORD_MAX || p <= WORD_MIN)
						begin
							mpsw[1:0] = 2'b10;
							ev[EV_DIVOVF] = 1'b1;
						end
						else
						begin
							mpsw = {p < 0, p == 0, 2'b00};
							mr[r] = p[15:0];
							p = m % $signed(s);
							mr[r + 3'h1] = p[15:0];
						end
					end
				end
			REG_XOR_OP:
			begin
				o = mr[r] ^ s;
				if (ins[5:3] == MODE_REGISTER)
					mr[ins[2:0]] = o;
				mpsw = {o[15], o == 16'h0, 1'b0, mpsw[0]};
				xfer(1'b0, OFF_RESULT, 32'h0, d);
				check("result", d, {16'h0, o});
			end
			default:
			begin
				case (ins & BRANCH_MASK)
					BRANCH_ALWAYS_OP: t = 1'b1;
					BRANCH_NOT_ZERO_OP: t = !mpsw[FLAG_Z];
					BRANCH_ZERO_OP: t = mpsw[FLAG_Z];
					default: t = mpsw[FLAG_N] == mpsw[FLAG_V];
				endcase
				if (t)
					mpc = mpc + {{7{ins[7]}}, ins[7:0], 1'b0};
			end
		endcase
		for (int i = 0; i < NREGS; i++)
		begin
			xfer(1'b0, 8'h40 + 8'(4 * i), 32'h0, d);
			check("gpr", d, {16'h0, mr[i]});
		end
		xfer(1'b0, OFF_PSW, 32'h0, d);
		check("psw", d, {28'h0, mpsw});
		xfer(1'b0, OFF_PC, 32'h0, d);
		check("pc", d, {16'h0, mpc});
		xfer(1'b0, OFF_IRQSTAT, 32'h0, d);
		check("irq status", d, {28'h0, ev});
	endtask

	////////////////////////////////////////
	// Main sequence
	initial
	begin
		logic [31:0] d;
		logic [15:0] ins, sop;
		logic signed [31:0] q;
		int op;
		error_cnt = 0;
		n_compared = 0;
		reset = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		void'($urandom(32'h386bde5f));
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 5; i++)
		begin
			xfer(1'b0, OFF_PSW + 8'(4 * i), 32'h0, d);
			check("reset value", d, 32'h0);
		end
		wr(8'h30, $urandom);
		xfer(1'b0, 8'h30, 32'h0, d);
		check("unmapped", d, 32'h0);
		for (int n = 0; n < 150; n++)
		begin
			for (int i = 0; i < NREGS; i++)
			begin
				mr[i] = 16'($urandom);
				wr(8'h40 + 8'(4 * i), {16'h0, mr[i]});
			end
			mpsw = 4'($urandom);
			mpc = 16'($urandom);
			wr(OFF_PSW, {28'h0, mpsw});
			wr(OFF_PC, {16'h0, mpc});
			sop = ($urandom_range(7, 0) == 0) ? 16'h0 : 16'($urandom);
			op = $urandom_range(6, 0);
			ins = 16'($urandom) & 16'h01ff;
			if (op > 2)
				ins = OPS[op] | {8'h0, (n % 3 == 0) ? 8'h80 : (n % 3 == 1) ? 8'h7f : ins[7:0]};
			else
				ins = ins | OPS[op];
			if (op == 1)
			begin
				ins[3] = 1'b1;
				if (!ins[6] && n % 2 == 0)
				begin
					q = $signed(mr[0]) * $signed(sop) - 32'sd3;
					{mr[ins[8:6]], mr[ins[8:6] + 3'h1]} = q;
					wr(8'h40 + 8'(4 * ins[8:6]), {16'h0, q[31:16]});
					wr(8'h44 + 8'(4 * ins[8:6]), {16'h0, q[15:0]});
				end
			end
			run(ins, sop);
		end
		// Divide by zero raises, clears and is masked
		wr(OFF_IRQSTAT, 32'hf);
		wr(OFF_IRQMASK, 32'h4);
		run(SIGNED_DIVIDE_OP | 16'h0008, 16'h0);
		check("irq", {31'h0, irq}, 32'h1);
		wr(OFF_IRQSTAT, 32'h4);
		repeat (2) @(posedge clk);
		check("irq", {31'h0, irq}, 32'h0);
		wr(OFF_IRQMASK, 32'h0);
		run(SIGNED_DIVIDE_OP | 16'h0088, 16'h0);
		xfer(1'b0, OFF_IRQSTAT, 32'h0, d);
		check("zero divide event", {31'h0, d[EV_DIVZERO]}, 32'h1);
		check("irq", {31'h0, irq}, 32'h0);
		stop_test();
	end
endmodule

`default_nettype wire
